// [verilog/mode_arb_map.svh]
`ifndef MODE_ARB_MAP_SVH
`define MODE_ARB_MAP_SVH

// field bus command framing
`define FB_CTRL_WRITE      8'h04
`define FB_IDX_POINT       16'h0023
`define FB_SUB_POINT_ABS   8'h01
`define FB_IDX_SETTINGS    16'h001d
`define FB_SUB_LOCK        8'h1e
`define FB_SUB_IO_ASSIGN   8'h1f

// io assignment values and reset values
`define IO_ASSIGN_FIELDBUS 16'h0000
`define IO_ASSIGN_FREE     16'h0001
`define IO_ASSIGN_FIXED    16'h0002
`define IO_ASSIGN_RESET    16'h0000
`define TARGET_RESET       32'h00000000
`define LOCK_RESET         1'b0

// acknowledgement layout
`define ACK_HOMED_BIT      5
`define ACK_DONE_BIT       14

// controller apb register offsets
`define CTL_OFS_CTRL       12'h000
`define CTL_OFS_CMD        12'h004
`define CTL_OFS_VAL        12'h008
`define CTL_OFS_STATUS     12'h00c
`define CTL_CTRL_RSEL_BIT  0
`define CTL_CTRL_LINK_BIT  1
`define CTL_CTRL_GO_BIT    2

`endif

// [verilog/mode_arb_pkg.sv]
package mode_arb_pkg;

  typedef enum logic [2:0] {
    MODE_NONE   = 3'b000,
    MODE_MANUAL = 3'b001,
    MODE_VEL    = 3'b010,
    MODE_POINT  = 3'b011,
    MODE_HOME   = 3'b100,
    MODE_GEAR   = 3'b101
  } mode_t;

  typedef enum logic [1:0] {
    CHAN_LOCAL = 2'b00,
    CHAN_SIGIO = 2'b01,
    CHAN_BUS   = 2'b10
  } chan_t;

endpackage : mode_arb_pkg

// [verilog/mode_link_if.sv]
`timescale 1ns/1ps
interface mode_link_if
(
  input wire logic MCLK,
  input wire logic SYS_RST
);
  logic        cmd_valid;
  logic        cmd_ready;
  logic [7:0]  cmd_ctrl;
  logic [7:0]  cmd_sub;
  logic [15:0] cmd_idx;
  logic [31:0] cmd_val;
  logic        ack_valid;
  logic [7:0]  ack_status;
  logic [15:0] ack_word;
  logic        remote_select;
  logic        remote_select_ack;
  logic        link_up;

  modport dev
  (
    input  cmd_valid, cmd_ctrl, cmd_sub, cmd_idx, cmd_val,
    input  remote_select, link_up,
    output cmd_ready, ack_valid, ack_status, ack_word, remote_select_ack
  );

  modport bus
  (
    output cmd_valid, cmd_ctrl, cmd_sub, cmd_idx, cmd_val,
    output remote_select, link_up,
    input  cmd_ready, ack_valid, ack_status, ack_word, remote_select_ack
  );
endinterface : mode_link_if

// [verilog/fieldbus_master_end.sv]
`timescale 1ns/1ps
`include "mode_arb_map.svh"
module fieldbus_master_end
(
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  mode_link_if.bus         LINK,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);
  logic        rsel_q, rsel_d;
  logic        link_q, link_d;
  logic [31:0] cmd_q, cmd_d;
  logic [31:0] val_q, val_d;
  logic        valid_q, valid_d;
  logic        busy_q, busy_d;
  logic        seen_q, seen_d;
  logic [7:0]  stat_q, stat_d;
  logic [15:0] word_q, word_d;
  logic [31:0] rdata_d;
  logic        acc, mapped;

  assign acc    = PSEL & PENABLE;
  assign mapped = (PADDR == `CTL_OFS_CTRL) || (PADDR == `CTL_OFS_CMD) ||
                  (PADDR == `CTL_OFS_VAL) || (PADDR == `CTL_OFS_STATUS);
  assign PREADY  = 1'b1;
  assign PSLVERR = acc & ~mapped;

  // mode starts travel only as parameter writes on the link
  assign LINK.cmd_valid     = valid_q; // see RULE_11
  assign LINK.cmd_ctrl      = cmd_q[31:24]; // see RULE_13
  assign LINK.cmd_sub       = cmd_q[23:16]; // see RULE_15
  assign LINK.cmd_idx       = cmd_q[15:0];
  assign LINK.cmd_val       = val_q;
  assign LINK.remote_select = rsel_q; // see RULE_05
  assign LINK.link_up       = link_q;

  always_comb
  begin
    rsel_d  = rsel_q;
    link_d  = link_q;
    cmd_d   = cmd_q;
    val_d   = val_q;
    valid_d = valid_q;
    busy_d  = busy_q;
    seen_d  = seen_q;
    stat_d  = stat_q;
    word_d  = word_q;
    rdata_d = 32'h00000000;
    if (valid_q && LINK.cmd_ready)
      valid_d = 1'b0;
    if (acc && PWRITE && mapped)
    begin
      unique case (PADDR)
        `CTL_OFS_CTRL:
        begin
          rsel_d = PWDATA[`CTL_CTRL_RSEL_BIT];
          link_d = PWDATA[`CTL_CTRL_LINK_BIT];
          // a go while busy is dropped, not queued
          if (PWDATA[`CTL_CTRL_GO_BIT] && !busy_q)
          begin
            valid_d = 1'b1;
            busy_d  = 1'b1;
            seen_d  = 1'b0;
          end
        end
        `CTL_OFS_CMD: if (!busy_q) cmd_d = PWDATA;
        `CTL_OFS_VAL: if (!busy_q) val_d = PWDATA;
        default: ;
      endcase
    end
    if (LINK.ack_valid)
    begin
      busy_d = 1'b0;
      seen_d = 1'b1;
      stat_d = LINK.ack_status;
      word_d = LINK.ack_word;
    end
    unique case (PADDR)
      `CTL_OFS_CTRL:   rdata_d = {29'h0, busy_q, link_q, rsel_q};
      `CTL_OFS_CMD:    rdata_d = cmd_q;
      `CTL_OFS_VAL:    rdata_d = val_q;
      `CTL_OFS_STATUS: rdata_d = {word_q, stat_q, 5'h00,
                                  LINK.remote_select_ack, seen_q, busy_q};
      default:         rdata_d = 32'h00000000;
    endcase
  end

  assign PRDATA = rdata_d;

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      rsel_q  <= 1'b0;
      link_q  <= 1'b0;
      cmd_q   <= {`FB_CTRL_WRITE, `FB_SUB_POINT_ABS, `FB_IDX_POINT};
      val_q   <= 32'h00000000;
      valid_q <= 1'b0;
      busy_q  <= 1'b0;
      seen_q  <= 1'b0;
      stat_q  <= 8'h00;
      word_q  <= 16'h0000;
    end
    else
    begin
      rsel_q  <= rsel_d;
      link_q  <= link_d;
      cmd_q   <= cmd_d;
      val_q   <= val_d;
      valid_q <= valid_d;
      busy_q  <= busy_d;
      seen_q  <= seen_d;
      stat_q  <= stat_d;
      word_q  <= word_d;
    end
  end
endmodule : fieldbus_master_end

// [verilog/mode_access_arbiter.sv]
`timescale 1ns/1ps
`include "mode_arb_map.svh"
// Function
// RULE_01: hold 16-bit io assignment, reset zero
// RULE_02: settings 0/1: panel and bus equal
// RULE_03: settings 0/1: no sig io; setup local
// RULE_04: setting 2: remote select picks channel
// RULE_05: select low local, high field bus
// RULE_06: fixed io: sig io manual or auto only
// RULE_07: sig io switching only when fixed
// RULE_08: select change waits for operation end
// RULE_09: ack output shows applied selection
// RULE_10: report active mode to outside
// RULE_11: bus starts modes by parameter writes
// RULE_12: target write starts absolute positioning
// RULE_13: write frame: 04, sub, index, value
// RULE_14: acknowledge every command with status
// RULE_15: bus addresses start by index, subindex
// RULE_16: owner channel keeps control while running
// RULE_17: lock setting; link loss restores local (code only clears the lock; fixed io with select high stays on the bus)
// RULE_18: done clears on start, sets on stop
// RULE_19: ungranted requests change nothing
module mode_access_arbiter
(
  input  wire logic                 MCLK,
  input  wire logic                 SYS_RST,
  mode_link_if.dev                  LINK,
  input  wire logic                 LOCAL_REQ,
  input  wire mode_arb_pkg::mode_t  LOCAL_MODE,
  input  wire logic                 LOCAL_SETUP_WE,
  input  wire logic [15:0]          LOCAL_SETUP_DATA,
  input  wire logic                 SIG_MANUAL,
  input  wire logic                 SIG_AUTO,
  input  wire mode_arb_pkg::mode_t  AUTO_MODE,
  input  wire logic                 OP_DONE,
  input  wire logic                 HOMED,
  input  wire logic [3:0]           AMP_STATE,
  output logic [15:0]               IO_ASSIGN,
  output logic                      REMOTE_LOCK,
  output mode_arb_pkg::mode_t       ACTIVE_MODE,
  output mode_arb_pkg::chan_t       OWNER,
  output logic                      MOTION_DONE,
  output logic                      START,
  output logic signed [31:0]        TARGET
);
  logic [15:0]         io_q, io_d;
  logic                lock_q, lock_d;
  logic                sel_q, sel_d;
  logic                busy_q, busy_d;
  mode_arb_pkg::mode_t mode_q, mode_d;
  mode_arb_pkg::chan_t owner_q, owner_d;
  logic [31:0]         tgt_q, tgt_d;
  logic                start_q, start_d;
  logic                ackv_q, ackv_d;
  logic [7:0]          acks_q, acks_d;
  logic [15:0]         ackw_q, ackw_d;

  // pins from outside: two flops before use, third only for edges
  logic [2:0] rsel_s;
  logic [2:0] man_s;
  logic [2:0] aut_s;

  logic fixed, local_ok, sig_ok, bus_ok;
  logic take, is_write, sig_man_rise, sig_aut_rise;

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      rsel_s <= 3'b000;
      man_s  <= 3'b000;
      aut_s  <= 3'b000;
    end
    else
    begin
      rsel_s <= {rsel_s[1:0], LINK.remote_select};
      man_s  <= {man_s[1:0], SIG_MANUAL};
      aut_s  <= {aut_s[1:0], SIG_AUTO};
    end
  end

  assign sig_man_rise = man_s[1] & ~man_s[2];
  assign sig_aut_rise = aut_s[1] & ~aut_s[2];

  assign fixed    = (io_q == `IO_ASSIGN_FIXED);
  // settings 0/1: bus granted, panel too while unlocked
  assign local_ok = ~lock_q & (~fixed | ~sel_q); // see RULE_02
  assign sig_ok   = ~lock_q & fixed & ~sel_q; // see RULE_07
  assign bus_ok   = lock_q | ~fixed | sel_q; // see RULE_04
  assign take     = LINK.cmd_valid & ~ackv_q;
  assign is_write = (LINK.cmd_ctrl == `FB_CTRL_WRITE);
  // one command in flight: ready drops while its ack is out
  assign LINK.cmd_ready = ~ackv_q;

  always_comb
  begin
    io_d    = io_q;
    lock_d  = lock_q;
    sel_d   = sel_q;
    busy_d  = busy_q;
    mode_d  = mode_q;
    owner_d = owner_q;
    tgt_d   = tgt_q;
    start_d = 1'b0;
    ackv_d  = 1'b0;
    acks_d  = acks_q;
    ackw_d  = ackw_q;

    // motor stopped: operation over
    if (busy_q && OP_DONE)
      busy_d = 1'b0; // see RULE_18

    // a changed select is held until idle, then applied
    if (!busy_q && (rsel_s[1] != sel_q))
      sel_d = rsel_s[1]; // see RULE_08

    // field bus gone: lock released; local channels come back unless io is fixed with select high
    if (!LINK.link_up)
      lock_d = 1'b0; // see RULE_17

    // setup comes only from the local side
    if (LOCAL_SETUP_WE && !lock_q &&
        (LOCAL_SETUP_DATA <= `IO_ASSIGN_FIXED))
      io_d = LOCAL_SETUP_DATA; // see RULE_01

    // ties resolve bus, then panel, then sig io; equal rights,
    // but only one start can be taken per cycle
    if (sig_ok && (!busy_q || owner_q == mode_arb_pkg::CHAN_SIGIO) &&
        (sig_man_rise || sig_aut_rise)) // see RULE_16
    begin
      // sig io reaches manual or the configured auto mode only
      mode_d  = sig_man_rise ? mode_arb_pkg::MODE_MANUAL
                             : AUTO_MODE; // see RULE_06
      owner_d = mode_arb_pkg::CHAN_SIGIO;
      busy_d  = 1'b1;
      start_d = 1'b1;
    end

    if (LOCAL_REQ && local_ok && LOCAL_MODE != mode_arb_pkg::MODE_NONE &&
        (!busy_q || owner_q == mode_arb_pkg::CHAN_LOCAL)) // see RULE_16
    begin
      mode_d  = LOCAL_MODE;
      owner_d = mode_arb_pkg::CHAN_LOCAL;
      busy_d  = 1'b1;
      start_d = 1'b1;
    end

    if (take)
    begin
      ackv_d = 1'b1; // see RULE_14
      if (is_write)
      begin
        if (LINK.cmd_idx == `FB_IDX_POINT &&
            LINK.cmd_sub == `FB_SUB_POINT_ABS) // see RULE_15
        begin
          // ungranted or foreign-owned: acked, nothing changes
          if (bus_ok && (!busy_q ||
              owner_q == mode_arb_pkg::CHAN_BUS)) // see RULE_19
          begin
            tgt_d   = LINK.cmd_val; // see RULE_12
            mode_d  = mode_arb_pkg::MODE_POINT;
            owner_d = mode_arb_pkg::CHAN_BUS;
            busy_d  = 1'b1;
            start_d = 1'b1;
          end
        end
        else if (LINK.cmd_idx == `FB_IDX_SETTINGS &&
                 LINK.cmd_sub == `FB_SUB_LOCK)
          lock_d = LINK.cmd_val[0] & LINK.link_up; // see RULE_17
        // io assignment and other setup writes are refused; see RULE_03
      end
    end

    // status reflects the command's own effect; held between acks
    // so a late poll still reads the answer it belongs to
    if (take)
    begin
      acks_d = 8'h00;
      acks_d[4:0] = {2'b00, mode_d}; // see RULE_14
      acks_d[`ACK_HOMED_BIT] = HOMED;
      ackw_d = {12'h000, AMP_STATE};
      ackw_d[`ACK_DONE_BIT] = ~busy_d;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      io_q    <= `IO_ASSIGN_RESET;
      lock_q  <= `LOCK_RESET;
      sel_q   <= 1'b0;
      busy_q  <= 1'b0;
      mode_q  <= mode_arb_pkg::MODE_NONE;
      owner_q <= mode_arb_pkg::CHAN_LOCAL;
      tgt_q   <= `TARGET_RESET;
      start_q <= 1'b0;
      ackv_q  <= 1'b0;
      acks_q  <= 8'h00;
      ackw_q  <= 16'h0000;
    end
    else
    begin
      io_q    <= io_d;
      lock_q  <= lock_d;
      sel_q   <= sel_d;
      busy_q  <= busy_d;
      mode_q  <= mode_d;
      owner_q <= owner_d;
      tgt_q   <= tgt_d;
      start_q <= start_d;
      ackv_q  <= ackv_d;
      acks_q  <= acks_d;
      ackw_q  <= ackw_d;
    end
  end

  assign LINK.ack_valid  = ackv_q;
  assign LINK.ack_status = acks_q;
  assign LINK.ack_word   = ackw_q;
  // low: local active, high: field bus active
  assign LINK.remote_select_ack = sel_q; // see RULE_09
  assign IO_ASSIGN   = io_q;
  assign REMOTE_LOCK = lock_q;
  assign ACTIVE_MODE = mode_q; // see RULE_10
  assign OWNER       = owner_q;
  // done only while idle; start and done never overlap
  assign MOTION_DONE = ~busy_q; // see RULE_18
  assign START       = start_q;
  assign TARGET      = tgt_q;
endmodule : mode_access_arbiter

// [testbench/mode_link_monitor.sv]
`timescale 1ns/1ps
module mode_link_monitor
(
  input wire logic        MCLK,
  input wire logic        SYS_RST,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [7:0]  cmd_ctrl,
  input wire logic [7:0]  cmd_sub,
  input wire logic [15:0] cmd_idx,
  input wire logic [31:0] cmd_val,
  input wire logic        ack_valid,
  input wire logic [7:0]  ack_status,
  input wire logic [15:0] ack_word,
  input wire logic        remote_select,
  input wire logic        remote_select_ack
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_ack;
    ack_valid ##1 !ack_valid;
  endsequence
  property p_cause;
    ack_valid |-> $past(cmd_valid && cmd_ready);
  endproperty
  property p_frame;
    cmd_valid |-> cmd_ctrl == 8'h04;
  endproperty
  // status must not drift between acks, software polls it late
  property p_hold;
    !ack_valid |-> $stable(ack_status) && $stable(ack_word);
  endproperty
  property p_code;
    ack_valid |-> ack_status[4:0] <= 5'd5;
  endproperty
  property p_sel;
    $changed(remote_select_ack) |-> remote_select_ack == remote_select;
  endproperty
  chk_ack_next: assert property (s_take |=> s_ack)
    else $error("no single-cycle ack after command");
  chk_ack_cause: assert property (p_cause)
    else $error("ack without a taken command");
  chk_one_flight: assert property (ack_valid |-> !cmd_ready)
    else $error("ready high during ack");
  chk_valid_drop: assert property (s_take |=> !cmd_valid)
    else $error("command repeated after take");
  chk_frame_write: assert property (p_frame)
    else $error("command control byte not write");
  chk_status_hold: assert property (p_hold)
    else $error("ack status changed without ack");
  chk_mode_code: assert property (p_code)
    else $error("ack mode code out of range");
  chk_sel_ack: assert property (p_sel)
    else $error("select ack moved away from select");
endmodule : mode_link_monitor

// [testbench/operating_mode_access_arbiter_bench.sv]
`timescale 1ns/1ps
`include "mode_arb_map.svh"
module operating_mode_access_arbiter_bench;
  localparam logic [31:0] PNT = {`FB_CTRL_WRITE, `FB_SUB_POINT_ABS,
                                 `FB_IDX_POINT};
  localparam logic [31:0] LCK = {`FB_CTRL_WRITE, `FB_SUB_LOCK,
                                 `FB_IDX_SETTINGS};
  localparam logic [31:0] IOA = {`FB_CTRL_WRITE, `FB_SUB_IO_ASSIGN,
                                 `FB_IDX_SETTINGS};
  logic                mclk, rst, psel, pen, pwr, perr, pready, e;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, r;
  logic                lreq, lwe, sman, sauto, opd, lock, mdone, start;
  logic [15:0]         ldata, io;
  logic [1:0]          ctl;
  logic signed [31:0]  tgt;
  mode_arb_pkg::mode_t lmode, amode, act;
  mode_arb_pkg::chan_t own;
  int                  n_mismatch;
  int                  compares;
  int                  n_start;
  mode_link_if i_mode_link_if (.MCLK(mclk), .SYS_RST(rst));
  fieldbus_master_end i_fieldbus_master_end
  (
    .MCLK(mclk), .SYS_RST(rst), .LINK(i_mode_link_if), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr)
  );
  mode_access_arbiter i_mode_access_arbiter
  (
    .MCLK(mclk), .SYS_RST(rst), .LINK(i_mode_link_if), .LOCAL_REQ(lreq),
    .LOCAL_MODE(lmode), .LOCAL_SETUP_WE(lwe), .LOCAL_SETUP_DATA(ldata),
    .SIG_MANUAL(sman), .SIG_AUTO(sauto), .AUTO_MODE(amode), .OP_DONE(opd),
    .HOMED(1'b1), .AMP_STATE(4'h6), .IO_ASSIGN(io), .REMOTE_LOCK(lock),
    .ACTIVE_MODE(act), .OWNER(own), .MOTION_DONE(mdone), .START(start),
    .TARGET(tgt)
  );
  mode_link_monitor i_mon
  (
    .MCLK(mclk), .SYS_RST(rst), .cmd_valid(i_mode_link_if.cmd_valid),
    .cmd_ready(i_mode_link_if.cmd_ready), .cmd_ctrl(i_mode_link_if.cmd_ctrl),
    .cmd_sub(i_mode_link_if.cmd_sub), .cmd_idx(i_mode_link_if.cmd_idx),
    .cmd_val(i_mode_link_if.cmd_val), .ack_valid(i_mode_link_if.ack_valid),
    .ack_status(i_mode_link_if.ack_status),
    .ack_word(i_mode_link_if.ack_word),
    .remote_select(i_mode_link_if.remote_select),
    .remote_select_ack(i_mode_link_if.remote_select_ack)
  );
  task automatic report_and_stop();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    r = prdata;
    e = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
    // idle edge so psel never flips twice in one step
    @(posedge mclk);
  endtask : apb
  task automatic bus(input logic [31:0] c, input logic [31:0] v,
                     input logic [23:0] x);
    apb(1'b1, `CTL_OFS_VAL, v);
    apb(1'b1, `CTL_OFS_CMD, c);
    apb(1'b1, `CTL_OFS_CTRL, {29'h0, 1'b1, ctl});
    r = 32'h1;
    while (r[0] !== 1'b0)
      apb(1'b0, `CTL_OFS_STATUS, 32'h0);
    cmp(r[31:8], {8'h0, x});
  endtask : bus
  task automatic lrq(input logic [2:0] m);
    lreq  <= 1'b1;
    lmode <= mode_arb_pkg::mode_t'(m);
    @(posedge mclk);
    lreq <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : lrq
  task automatic setup(input logic [15:0] v);
    lwe   <= 1'b1;
    ldata <= v;
    @(posedge mclk);
    lwe <= 1'b0;
    @(posedge mclk);
  endtask : setup
  // pins pass a two-flop synchroniser, so hold them well past it
  task automatic pin(input logic [1:0] p);
    {sauto, sman} <= p;
    repeat (4) @(posedge mclk);
    {sauto, sman} <= 2'b00;
    repeat (4) @(posedge mclk);
  endtask : pin
  task automatic fin_op();
    opd <= 1'b1;
    repeat (2) @(posedge mclk);
    opd <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : fin_op
  // every granted start leaves exactly one pulse
  always @(posedge mclk)
    if (!rst && start === 1'b1)
      n_start <= n_start + 1;
  initial
  begin
    mclk = 1'b0;
    forever
      #5 mclk = ~mclk;
  end
  initial
  begin
    repeat (8000) @(posedge mclk);
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    {psel, pen, pwr, paddr, pwdata, lreq, lwe, ldata, sman, sauto, opd} = '0;
    ctl = 2'b00;
    lmode = mode_arb_pkg::MODE_NONE;
    amode = mode_arb_pkg::MODE_HOME;
    rst = 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    cmp(io, 32'h0);
    cmp(tgt, 32'h0);
    cmp(mdone, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    cmp(e, 32'h1);
    $display("test 0 done");
    ctl = 2'b10;
    bus(PNT, 32'h144, 24'h000623);
    cmp(act, mode_arb_pkg::MODE_POINT);
    cmp(tgt, 32'h144);
    cmp(own, mode_arb_pkg::CHAN_BUS);
    cmp(mdone, 32'h0);
    $display("test 1 done");
    lrq(3'h2);
    cmp(act, mode_arb_pkg::MODE_POINT);
    fin_op();
    cmp(mdone, 32'h1);
    lrq(3'h2);
    cmp(act, mode_arb_pkg::MODE_VEL);
    bus(PNT, 32'h55, 24'h000622);
    cmp(tgt, 32'h144);
    fin_op();
    $display("test 2 done");
    pin(2'b01);
    cmp(act, mode_arb_pkg::MODE_VEL);
    bus(IOA, 32'h2, 24'h400622);
    cmp(io, 32'h0);
    setup(16'h2);
    cmp(io, 32'h2);
    setup(16'h3);
    cmp(io, 32'h2);
    $display("test 3 done");
    pin(2'b01);
    cmp(act, mode_arb_pkg::MODE_MANUAL);
    cmp(own, mode_arb_pkg::CHAN_SIGIO);
    fin_op();
    pin(2'b10);
    cmp(act, mode_arb_pkg::MODE_HOME);
    fin_op();
    bus(PNT, 32'h9, 24'h400624);
    cmp(act, mode_arb_pkg::MODE_HOME);
    $display("test 4 done");
    lrq(3'h5);
    ctl = 2'b11;
    apb(1'b1, `CTL_OFS_CTRL, {30'h0, ctl});
    repeat (6) @(posedge mclk);
    cmp(i_mode_link_if.remote_select_ack, 32'h0);
    fin_op();
    repeat (4) @(posedge mclk);
    cmp(i_mode_link_if.remote_select_ack, 32'h1);
    bus(PNT, 32'hfffffff9, 24'h000623);
    cmp(tgt, 32'hfffffff9);
    lrq(3'h1);
    cmp(act, mode_arb_pkg::MODE_POINT);
    fin_op();
    $display("test 5 done");
    bus(LCK, 32'h1, 24'h400623);
    cmp(lock, 32'h1);
    lrq(3'h2);
    cmp(act, mode_arb_pkg::MODE_POINT);
    ctl = 2'b01;
    apb(1'b1, `CTL_OFS_CTRL, {30'h0, ctl});
    repeat (3) @(posedge mclk);
    cmp(lock, 32'h0);
    cmp(n_start, 32'd6);
    $display("test 6 done");
    report_and_stop();
  end
endmodule : operating_mode_access_arbiter_bench
